/* hdl/tgm_defs.svh */
// Constants for the timer guard, monitor and transfer glue
`ifndef TGM_DEFS_SVH
`define TGM_DEFS_SVH
`define TGM_UNITS 2
`define TGM_PKT_N 8
`define TGM_PKT_IW 3
`define TGM_PKT_W 96
`define TGM_CH1_N 32
`define TGM_CH2_N 18
`define TGM_GPIO_W 8
`define TGM_DIS1_BIT 5
`define TGM_DIS2_BIT 2
`define TGM_CMP1_CH 31
`define TGM_CMP2_CH 0
`define TGM_TSTEP_NARROW 16'h0008
`define TGM_TSTEP_WIDE 16'h0010
`define TGM_MSTEP_32 32'h0000_0004
`define TGM_MSTEP_64 32'h0000_0008
`define TGM_CH2_PAD 14'h0000
`endif

/* hdl/tgm_pkg.sv */
// Types shared by the timer glue design
package tgm_pkg;
  `include "tgm_defs.svh"

  typedef enum logic [1:0] {TGM_ONE_SHOT, TGM_CIRCULAR, TGM_AUTO_SWITCH} tgm_mode_type;
  typedef enum logic [1:0] {TGM_MEM_FIXED, TGM_MEM_STEP32, TGM_MEM_STEP64} tgm_mstep_type;
  typedef enum logic [1:0] {TGM_IDLE, TGM_FETCH, TGM_ISSUE, TGM_WAIT} tgm_xfer_type;

  typedef struct packed {
    logic [31:0] mem_a;
    logic [31:0] mem_b;
    logic [15:0] tmr_base;
    logic [7:0] count;
    tgm_mode_type mode;
    tgm_mstep_type mstep;
    logic tstep16;
    logic wide;
    logic to_mem;
  } tgm_pkt_type;

  typedef struct packed {
    logic req;
    logic [31:0] mem_addr;
    logic [15:0] tmr_addr;
    logic to_mem;
    logic wide;
  } tgm_mst_type;

  typedef struct packed {
    tgm_xfer_type st;
    logic [`TGM_PKT_IW-1:0] idx;
    logic [`TGM_PKT_N-1:0] en;
    logic [`TGM_PKT_N-1:0] pend;
    logic [`TGM_PKT_N-1:0] lost;
    logic [`TGM_PKT_N-1:0] bufsel;
    logic [7:0] cnt;
    tgm_pkt_type cur;
    tgm_mst_type mst;
    logic par_err;
    logic mpu_err;
    logic busy;
  } tgm_unit_type;

  typedef struct packed {
    logic [`TGM_CH1_N-1:0] pin1;
    logic [`TGM_CH1_N-1:0] oe1;
    logic [`TGM_CH2_N-1:0] pin2;
    logic [`TGM_CH2_N-1:0] oe2;
    logic [`TGM_CH1_N-1:0] mon1;
    logic [`TGM_CH2_N-1:0] mon2;
    logic cmp1;
    logic cmp2;
    tgm_unit_type [`TGM_UNITS-1:0] u;
  } tgm_state_type;
endpackage

/* hdl/tgm_pkt_ram.sv */
// Control packet storage with registered read data
`timescale 1ns/1ps
module tgm_pkt_ram #(
  parameter int W = 96,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);
  logic [W-1:0] mem_r [D];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (rd_en_in) begin
      rdata_out <= mem_r[raddr_in];
    end
  end
endmodule // tgm_pkt_ram

/* hdl/tgm_glue.sv */
// Pin disable, cross monitoring, comparator taps and transfer units of two timers
// Operation
// - Disable low tri-states masked timer outputs
// - Port A bit 5, port B bit 2
// - Instance one channel 31 to comparator one
// - Instance two channel 0 to comparator two
// - Taps ahead of pad; internal-only channels
// - Timers observe each other, direction selectable
// - Eight request lines trigger matching packets
// - Eight packets each with two buffers
// - Packets in parity RAM, checked on read
// - 32/64-bit beats, 8/16 and fixed/4/8 steps
// - One-shot, circular and auto-switch buffer modes
// - Own protection window checks memory addresses
`timescale 1ns/1ps
`include "tgm_defs.svh"
module tgm_glue
  import tgm_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [`TGM_CH1_N-1:0] tmr1_out_in,
  input wire logic [`TGM_CH1_N-1:0] tmr1_oe_in,
  input wire logic [`TGM_CH2_N-1:0] tmr2_out_in,
  input wire logic [`TGM_CH2_N-1:0] tmr2_oe_in,
  input wire logic [`TGM_CH1_N-1:0] output_disable_mask_1_in,
  input wire logic [`TGM_CH2_N-1:0] output_disable_mask_2_in,
  input wire logic [`TGM_GPIO_W-1:0] gpio_port_a_in,
  input wire logic [`TGM_GPIO_W-1:0] gpio_port_b_in,
  input wire logic [1:0] internal_only_in,
  input wire logic monitor_dir_in,
  input wire logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] transfer_request_line_in,
  input wire logic [`TGM_UNITS-1:0] pkt_wr_in,
  input wire logic [`TGM_UNITS-1:0][`TGM_PKT_IW-1:0] pkt_idx_in,
  input wire tgm_pkt_type [`TGM_UNITS-1:0] pkt_data_in,
  input wire logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] pkt_disable_in,
  input wire logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] lost_clr_in,
  input wire logic [`TGM_UNITS-1:0] err_clr_in,
  input wire logic [`TGM_UNITS-1:0] mpu_en_in,
  input wire logic [`TGM_UNITS-1:0][31:0] mpu_lo_in,
  input wire logic [`TGM_UNITS-1:0][31:0] mpu_hi_in,
  input wire logic [`TGM_UNITS-1:0] mst_ack_in,
  output logic [`TGM_CH1_N-1:0] tmr1_pin_out,
  output logic [`TGM_CH1_N-1:0] tmr1_pin_oe_out,
  output logic [`TGM_CH2_N-1:0] tmr2_pin_out,
  output logic [`TGM_CH2_N-1:0] tmr2_pin_oe_out,
  output logic [`TGM_CH1_N-1:0] tmr1_monitor_out,
  output logic [`TGM_CH2_N-1:0] tmr2_monitor_out,
  output logic clock_comparator_one_clk_out,
  output logic clock_comparator_two_clk_out,
  output tgm_mst_type [`TGM_UNITS-1:0] mst_out,
  output logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] pkt_en_out,
  output logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] req_lost_out,
  output logic [`TGM_UNITS-1:0][`TGM_PKT_N-1:0] buf_sel_out,
  output logic [`TGM_UNITS-1:0] parity_err_out,
  output logic [`TGM_UNITS-1:0] mpu_err_out,
  output logic [`TGM_UNITS-1:0] busy_out
);
  tgm_state_type state_r;
  tgm_state_type state_nxt;
  logic [`TGM_UNITS-1:0] rd_en;
  logic [`TGM_UNITS-1:0][`TGM_PKT_W-1:0] rd_data;
  logic [`TGM_UNITS-1:0][`TGM_PKT_W-1:0] wr_word;

  // ==========================================================
  // Packet RAM, one per transfer unit
  genvar g;
  generate
    for (g = 0; g < `TGM_UNITS; g++) begin : g_unit
      // Even parity kept in the top bit
      assign wr_word[g] = {^pkt_data_in[g], pkt_data_in[g]};
      tgm_pkt_ram #(
        .W(`TGM_PKT_W),
        .D(`TGM_PKT_N),
        .AW(`TGM_PKT_IW)
      ) u_ram (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(pkt_wr_in[g]),
        .waddr_in(pkt_idx_in[g]),
        .wdata_in(wr_word[g]),
        .rd_en_in(rd_en[g]),
        .raddr_in(state_r.u[g].idx),
        .rdata_out(rd_data[g])
      );
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    logic dis1;
    logic dis2;
    logic [`TGM_PKT_N-1:0] done;
    logic [`TGM_PKT_N-1:0] kill;
    logic [31:0] off;
    logic [31:0] base;
    logic [31:0] maddr;
    logic [15:0] taddr;
    logic last;
    tgm_pkt_type pk;
    dis1 = 1'b0;
    dis2 = 1'b0;
    done = '0;
    kill = '0;
    off = '0;
    base = '0;
    maddr = '0;
    taddr = '0;
    last = 1'b0;
    pk = '0;
    state_nxt = state_r;
    rd_en = '0;

    // Disable is active low on the GPIO bits
    dis1 = ~gpio_port_a_in[`TGM_DIS1_BIT];
    dis2 = ~gpio_port_b_in[`TGM_DIS2_BIT];
    state_nxt.pin1 = tmr1_out_in;
    state_nxt.pin2 = tmr2_out_in;
    state_nxt.oe1 = tmr1_oe_in & ~({`TGM_CH1_N{dis1}} & output_disable_mask_1_in);
    state_nxt.oe2 = tmr2_oe_in & ~({`TGM_CH2_N{dis2}} & output_disable_mask_2_in);
    // Internal-only keeps the pad quiet; the tap still sees the raw output
    if (internal_only_in[0]) begin
      state_nxt.oe1[`TGM_CMP1_CH] = 1'b0;
    end
    if (internal_only_in[1]) begin
      state_nxt.oe2[`TGM_CMP2_CH] = 1'b0;
    end
    state_nxt.cmp1 = tmr1_out_in[`TGM_CMP1_CH];
    state_nxt.cmp2 = tmr2_out_in[`TGM_CMP2_CH];
    // Only one direction live, so no loop can form between the timers
    state_nxt.mon1 = monitor_dir_in ? '0 : {`TGM_CH2_PAD, tmr2_out_in};
    state_nxt.mon2 = monitor_dir_in ? tmr1_out_in[`TGM_CH2_N-1:0] : '0;

    for (int u = 0; u < `TGM_UNITS; u++) begin
      done = '0;
      kill = '0;
      pk = state_r.u[u].cur;
      // Clear first so an error raised below in the same cycle still lands
      if (err_clr_in[u]) begin
        state_nxt.u[u].par_err = 1'b0;
        state_nxt.u[u].mpu_err = 1'b0;
      end
      base = state_r.u[u].bufsel[state_r.u[u].idx] ? pk.mem_b : pk.mem_a;
      case (pk.mstep)
        TGM_MEM_STEP32: off = {24'h00_0000, state_r.u[u].cnt} * `TGM_MSTEP_32;
        TGM_MEM_STEP64: off = {24'h00_0000, state_r.u[u].cnt} * `TGM_MSTEP_64;
        default: off = '0;
      endcase
      maddr = base + off;
      taddr = pk.tmr_base + 16'(state_r.u[u].cnt) *
              (pk.tstep16 ? `TGM_TSTEP_WIDE : `TGM_TSTEP_NARROW);
      last = (state_r.u[u].cnt + 8'h01) >= pk.count;

      case (state_r.u[u].st)
        TGM_IDLE: begin
          if ((state_r.u[u].pend & state_r.u[u].en) != '0) begin
            // Lowest packet number wins
            for (int p = `TGM_PKT_N - 1; p >= 0; p--) begin
              if (state_r.u[u].pend[p] && state_r.u[u].en[p]) begin
                state_nxt.u[u].idx = p[`TGM_PKT_IW-1:0];
              end
            end
            state_nxt.u[u].st = TGM_FETCH;
          end
        end
        TGM_FETCH: begin
          // Index is stable now; data lands next cycle in ISSUE entry
          rd_en[u] = 1'b1;
          state_nxt.u[u].cnt = '0;
          state_nxt.u[u].st = TGM_ISSUE;
          state_nxt.u[u].cur = '0;
          state_nxt.u[u].mst.req = 1'b0;
        end
        TGM_ISSUE: begin
          if (state_r.u[u].cur.count == '0 && state_r.u[u].cnt == '0 &&
              !state_r.u[u].mst.req && state_r.u[u].cur == '0) begin
            if (^rd_data[u]) begin
              state_nxt.u[u].par_err = 1'b1;
              kill[state_r.u[u].idx] = 1'b1;
              state_nxt.u[u].st = TGM_IDLE;
            end else begin
              state_nxt.u[u].cur = rd_data[u][`TGM_PKT_W-2:0];
              state_nxt.u[u].mst.to_mem = rd_data[u][0];
            end
          end
          if (state_r.u[u].cur != '0) begin
            if (mpu_en_in[u] && (maddr < mpu_lo_in[u] || maddr > mpu_hi_in[u])) begin
              state_nxt.u[u].mpu_err = 1'b1;
              kill[state_r.u[u].idx] = 1'b1;
              state_nxt.u[u].st = TGM_IDLE;
            end else begin
              state_nxt.u[u].mst.req = 1'b1;
              state_nxt.u[u].mst.mem_addr = maddr;
              state_nxt.u[u].mst.tmr_addr = taddr;
              state_nxt.u[u].mst.to_mem = pk.to_mem;
              state_nxt.u[u].mst.wide = pk.wide;
              state_nxt.u[u].st = TGM_WAIT;
            end
          end
        end
        TGM_WAIT: begin
          if (mst_ack_in[u]) begin
            state_nxt.u[u].mst.req = 1'b0;
            state_nxt.u[u].cnt = state_r.u[u].cnt + 8'h01;
            state_nxt.u[u].st = last ? TGM_IDLE : TGM_ISSUE;
            if (last) begin
              done[state_r.u[u].idx] = 1'b1;
              case (pk.mode)
                TGM_ONE_SHOT: kill[state_r.u[u].idx] = 1'b1;
                TGM_AUTO_SWITCH: state_nxt.u[u].bufsel[state_r.u[u].idx] =
                  ~state_r.u[u].bufsel[state_r.u[u].idx];
                default: ; // Circular reuses the same buffer
              endcase
            end
          end
        end
        default: state_nxt.u[u].st = TGM_IDLE;
      endcase

      // Request n pends packet n of this unit only
      state_nxt.u[u].pend = (state_r.u[u].pend & ~done & ~kill) |
                            (transfer_request_line_in[u] & state_r.u[u].en);
      // Set wins over clear
      state_nxt.u[u].lost = (state_r.u[u].lost & ~lost_clr_in[u]) |
        (transfer_request_line_in[u] & state_r.u[u].pend & ~done & ~kill);
      state_nxt.u[u].en = (state_r.u[u].en & ~kill & ~pkt_disable_in[u]) |
        ({`TGM_PKT_N{pkt_wr_in[u]}} & (`TGM_PKT_N'(1) << pkt_idx_in[u]));
      if (pkt_wr_in[u]) begin
        state_nxt.u[u].bufsel[pkt_idx_in[u]] = 1'b0;
      end
      state_nxt.u[u].busy = (state_nxt.u[u].st != TGM_IDLE);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from state
  assign tmr1_pin_out = state_r.pin1;
  assign tmr1_pin_oe_out = state_r.oe1;
  assign tmr2_pin_out = state_r.pin2;
  assign tmr2_pin_oe_out = state_r.oe2;
  assign tmr1_monitor_out = state_r.mon1;
  assign tmr2_monitor_out = state_r.mon2;
  assign clock_comparator_one_clk_out = state_r.cmp1;
  assign clock_comparator_two_clk_out = state_r.cmp2;
  generate
    for (g = 0; g < `TGM_UNITS; g++) begin : g_out
      assign mst_out[g] = state_r.u[g].mst;
      assign pkt_en_out[g] = state_r.u[g].en;
      assign req_lost_out[g] = state_r.u[g].lost;
      assign buf_sel_out[g] = state_r.u[g].bufsel;
      assign parity_err_out[g] = state_r.u[g].par_err;
      assign mpu_err_out[g] = state_r.u[g].mpu_err;
      assign busy_out[g] = state_r.u[g].busy;
    end
  endgenerate
endmodule // tgm_glue

/* testbench/tgm_glue_monitor.sv */
// Assertion checker on the timer glue ports
`timescale 1ns/1ps
module tgm_glue_monitor
  import tgm_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [31:0] tmr1_out_in,
  input wire logic [31:0] tmr1_oe_in,
  input wire logic [17:0] tmr2_out_in,
  input wire logic [17:0] tmr2_oe_in,
  input wire logic [31:0] output_disable_mask_1_in,
  input wire logic [17:0] output_disable_mask_2_in,
  input wire logic [7:0] gpio_port_a_in,
  input wire logic [7:0] gpio_port_b_in,
  input wire logic [1:0] internal_only_in,
  input wire logic monitor_dir_in,
  input wire logic [1:0][7:0] lost_clr_in,
  input wire logic [1:0] mpu_en_in,
  input wire logic [1:0][31:0] mpu_lo_in,
  input wire logic [1:0][31:0] mpu_hi_in,
  input wire logic [1:0] mst_ack_in,
  input wire logic [31:0] tmr1_pin_oe_out,
  input wire logic [17:0] tmr2_pin_oe_out,
  input wire logic [31:0] tmr1_monitor_out,
  input wire logic [17:0] tmr2_monitor_out,
  input wire logic clock_comparator_one_clk_out,
  input wire logic clock_comparator_two_clk_out,
  input wire tgm_mst_type [1:0] mst_out,
  input wire logic [1:0][7:0] req_lost_out
);
  // ==========
  // Pad, tap and transfer relations
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_pad_enable_one:
    assert property (1 |=> tmr1_pin_oe_out == $past(tmr1_oe_in & ~{internal_only_in[0], 31'h0}
      & ~(output_disable_mask_1_in & {32{~gpio_port_a_in[5]}}))) else $error("pad enable one");
  a_pad_enable_two:
    assert property (1 |=> tmr2_pin_oe_out == $past(tmr2_oe_in & ~{17'h0, internal_only_in[1]}
      & ~(output_disable_mask_2_in & {18{~gpio_port_b_in[2]}}))) else $error("pad enable two");
  a_tap_one:
    assert property (1 |=> clock_comparator_one_clk_out == $past(tmr1_out_in[31]))
      else $error("tap one");
  a_tap_two:
    assert property (1 |=> clock_comparator_two_clk_out == $past(tmr2_out_in[0]))
      else $error("tap two");
  a_monitor_dir:
    assert property (!monitor_dir_in |=> tmr2_monitor_out == 18'h0
      && tmr1_monitor_out == {14'h0, $past(tmr2_out_in)}) else $error("monitor path");
  a_beat_hold:
    assert property (mst_out[1].req && !mst_ack_in[1] |=> mst_out[1].req
      && $stable(mst_out[1].mem_addr) && $stable(mst_out[1].tmr_addr)) else $error("beat hold");
  a_ack_release:
    assert property (mst_out[0].req && mst_ack_in[0] |=> !mst_out[0].req) else $error("ack");
  a_mpu_window:
    assert property (mpu_en_in[0] && mst_out[0].req |-> mst_out[0].mem_addr >= mpu_lo_in[0]
      && mst_out[0].mem_addr <= mpu_hi_in[0]) else $error("window");
  a_lost_sticky:
    assert property (1 |=> ($past(req_lost_out[1] & ~lost_clr_in[1]) & ~req_lost_out[1]) == 8'h00)
      else $error("lost flag dropped");
  cover property (mst_out[1].req && mst_ack_in[1]);
  cover property (req_lost_out[1] != 8'h00);
  cover property (!gpio_port_b_in[2]);
endmodule // tgm_glue_monitor

bind tgm_glue tgm_glue_monitor i_tgm_glue_monitor (.clk_in, .nrst_in, .tmr1_out_in, .tmr1_oe_in,
  .tmr2_out_in, .tmr2_oe_in, .output_disable_mask_1_in, .output_disable_mask_2_in,
  .gpio_port_a_in, .gpio_port_b_in, .internal_only_in, .monitor_dir_in, .lost_clr_in,
  .mpu_en_in, .mpu_lo_in, .mpu_hi_in, .mst_ack_in, .tmr1_pin_oe_out, .tmr2_pin_oe_out,
  .tmr1_monitor_out, .tmr2_monitor_out, .clock_comparator_one_clk_out,
  .clock_comparator_two_clk_out, .mst_out, .req_lost_out);

/* testbench/tgm_mem_model.sv */
// Memory side responder acking transfer beats
`timescale 1ns/1ps
module tgm_mem_model #(
  parameter int LAT = 0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req_in,
  output logic ack_out
);
  // ==========
  // One ack per beat; a spare cycle after it so a late request drop is never acked
  int cnt;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in || ack_out || !req_in) begin
      ack_out <= 1'b0;
      cnt <= -1;
    end else if (cnt >= LAT) begin
      ack_out <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // tgm_mem_model

/* testbench/tgm_glue_test.sv */
// Self-checking bench for the timer glue
`timescale 1ns/1ps
`include "tgm_defs.svh"
module tgm_glue_test;
  import tgm_pkg::*;
  // ==========
  // Signals
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [31:0] t1o = 32'hA5C3_0F81, t1e = 32'hFFFF_FFFF, m1 = 32'h8000_FF00, p1, pe1, mo1;
  logic [17:0] t2o = 18'h2_5A5A, t2e = 18'h3_FFFF, m2 = 18'h0_00F1, p2, pe2, mo2;
  logic [7:0] ga = 8'hFF, gb = 8'hFF;
  logic [1:0] io = 2'h0, wr = 2'h0, ec = 2'h0, me = 2'h0, ack, perr, merr, busy;
  logic md = 1'b0, c1, c2;
  logic [1:0][7:0] rq = '0, dis = '0, lc = '0, en, lost, bs;
  logic [1:0][2:0] pi = '0;
  logic [1:0][31:0] lo = '0, hi = '0;
  tgm_pkt_type [1:0] pd = '0;
  tgm_mst_type [1:0] mst;
  tgm_pkt_type p = '0;
  logic [49:0] q[2][$];
  int bad_count = 0, num_checks = 0;
  always #5 clk_in = ~clk_in;
  tgm_glue i_tgm_glue (.clk_in, .nrst_in, .tmr1_out_in(t1o), .tmr1_oe_in(t1e), .tmr2_out_in(t2o),
    .tmr2_oe_in(t2e), .output_disable_mask_1_in(m1), .output_disable_mask_2_in(m2),
    .gpio_port_a_in(ga), .gpio_port_b_in(gb), .internal_only_in(io), .monitor_dir_in(md),
    .transfer_request_line_in(rq), .pkt_wr_in(wr), .pkt_idx_in(pi), .pkt_data_in(pd),
    .pkt_disable_in(dis), .lost_clr_in(lc), .err_clr_in(ec), .mpu_en_in(me), .mpu_lo_in(lo),
    .mpu_hi_in(hi), .mst_ack_in(ack), .tmr1_pin_out(p1), .tmr1_pin_oe_out(pe1),
    .tmr2_pin_out(p2), .tmr2_pin_oe_out(pe2), .tmr1_monitor_out(mo1), .tmr2_monitor_out(mo2),
    .clock_comparator_one_clk_out(c1), .clock_comparator_two_clk_out(c2), .mst_out(mst),
    .pkt_en_out(en), .req_lost_out(lost), .buf_sel_out(bs), .parity_err_out(perr),
    .mpu_err_out(merr), .busy_out(busy));
  // Unit zero answers promptly, unit one stalls
  tgm_mem_model #(.LAT(0)) i_mem0 (.clk_in, .nrst_in, .req_in(mst[0].req), .ack_out(ack[0]));
  tgm_mem_model #(.LAT(3)) i_mem1 (.clk_in, .nrst_in, .req_in(mst[1].req), .ack_out(ack[1]));
  always @(posedge clk_in) begin
    for (int u = 0; u < 2; u++) if (mst[u].req === 1'b1 && ack[u] === 1'b1)
      q[u].push_back({mst[u].mem_addr, mst[u].tmr_addr, mst[u].to_mem, mst[u].wide});
  end
  // ==========
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int u, input int i, input bit w);
    @(posedge clk_in);
    if (w) begin
      wr[u] <= 1'b1;
      pi[u] <= 3'(i);
      pd[u] <= p;
    end else begin
      rq[u][i] <= 1'b1;
    end
    @(posedge clk_in);
    wr[u] <= 1'b0;
    rq[u] <= '0;
  endtask
  task automatic drain(input int u);
    repeat (5) @(posedge clk_in);
    for (int n = 0; n < 300 && busy[u] !== 1'b0; n++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    logic [31:0] ma, ms;
    logic [15:0] ts;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      ga <= k[0] ? 8'hFF : 8'hDF;
      gb <= k[1] ? 8'hFF : 8'hFB;
      io <= 2'(k);
      md <= k[0];
      t1o <= ~t1o;
      t2o <= ~t2o;
      repeat (2) @(negedge clk_in);
      chk(pe1, t1e & ~(m1 & {32{~ga[5]}}) & ~{io[0], 31'h0});
      chk(pe2, t2e & ~(m2 & {18{~gb[2]}}) & ~{17'h0, io[1]});
      chk({c1, c2}, {t1o[31], t2o[0]});
      chk(mo1, md ? 32'h0 : {14'h0, t2o});
      chk(mo2, md ? t1o[17:0] : 18'h0);
      chk({p1, p2}, {t1o, t2o});
    end
    // Every line and mode, two rounds each so one-shot end and buffer swap show
    for (int u = 0; u < 2; u++) for (int i = 0; i < 8; i++) begin
      p.mem_a = 32'h2000_0000 + 32'(i * 256);
      p.mem_b = p.mem_a + 32'h1000_0000;
      p.tmr_base = 16'(i * 64);
      p.count = 8'h02;
      p.mode = tgm_mode_type'(i % 3);
      p.mstep = tgm_mstep_type'(i % 3);
      p.tstep16 = i[0];
      p.wide = i[1];
      p.to_mem = i[2];
      ms = (i % 3 == 0) ? 32'h0 : (i % 3 == 1) ? `TGM_MSTEP_32 : `TGM_MSTEP_64;
      ts = i[0] ? `TGM_TSTEP_WIDE : `TGM_TSTEP_NARROW;
      pulse(u, i, 1'b1);
      @(negedge clk_in);
      chk({en[u][i], bs[u][i]}, 2'h2);
      for (int r = 0; r < 2; r++) begin
        q[u].delete();
        pulse(u, i, 1'b0);
        drain(u);
        ma = (r == 1 && i % 3 == 2) ? p.mem_b : p.mem_a;
        chk(q[u].size(), (i % 3 == 0 && r == 1) ? 0 : 2);
        for (int j = 0; j < q[u].size(); j++)
          chk(q[u][j],
              {ma + 32'(j) * ms, p.tmr_base + 16'(j) * ts, p.to_mem, p.wide});
        chk({en[u][i], bs[u][i]}, {i % 3 != 0, r == 0 && i % 3 == 2});
      end
    end
    // Repeat request while the slow unit is busy on a lower packet
    pulse(1, 1, 1'b0);
    pulse(1, 4, 1'b0);
    pulse(1, 4, 1'b0);
    drain(1);
    drain(1);
    chk(lost[1], 8'h10);
    @(posedge clk_in);
    lc[1] <= 8'h10;
    @(posedge clk_in);
    lc[1] <= 8'h00;
    @(negedge clk_in);
    chk(lost[1], 8'h00);
    // A disabled packet ignores its request line
    @(posedge clk_in);
    dis[1] <= 8'h02;
    @(posedge clk_in);
    dis[1] <= 8'h00;
    pulse(1, 1, 1'b0);
    drain(1);
    chk({en[1][1], busy[1]}, 2'h0);
    // Window edges are inclusive; packet seven lies outside
    @(posedge clk_in);
    me[0] <= 1'b1;
    lo[0] <= 32'h2000_0100;
    hi[0] <= 32'h2000_0104;
    q[0].delete();
    pulse(0, 7, 1'b0);
    drain(0);
    chk({merr[0], en[0][7], 8'(q[0].size())}, 10'h200);
    pulse(0, 1, 1'b0);
    drain(0);
    chk(q[0].size(), 2);
    @(posedge clk_in);
    ec[0] <= 1'b1;
    @(posedge clk_in);
    ec[0] <= 1'b0;
    @(negedge clk_in);
    chk({merr, perr}, 4'h0);
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule // tgm_glue_test
